// [logic/dac_ctrl_consts.svh]
`ifndef DAC_CTRL_CONSTS_SVH
`define DAC_CTRL_CONSTS_SVH

// serial word layout
`define WORD_BITS          16
`define BIT_TARGET_SUB     15
`define BIT_MODE_LO        14
`define BIT_MODE_HI        13
`define ADDR_MSB           12
`define ADDR_LSB           10
`define MAIN_MSB           9
`define MAIN_LSB           0
`define SUB_MSB            9
`define SUB_LSB            2
// global control field positions
`define BIT_CODING         6
`define BIT_POWER_DOWN_N   5
`define BIT_GLOBAL_CHANNEL_STANDBY_N    4
`define BIT_GLOBAL_CLR     3
// channel control field positions
`define BIT_REF_HI         9
`define BIT_REF_LO         8
`define BIT_CHAN_CHANNEL_STANDBY_N_N    4
`define BIT_CHAN_CLR       3
// reset values of control state
`define RST_POWER_DOWN_N   1'b1
`define RST_GLOBAL_CHANNEL_STANDBY_N    1'b1
`define RST_CODING         1'b0
`define RST_CHAN_CHANNEL_STANDBY_N_N    1'b1
`define RST_CHAN_CLR       1'b0
`define RST_REF_SEL        2'h0
// clear codes
`define MAIN_MID           10'h200
`define MAIN_LOW           10'h000
`define SUB_MID_BIN        8'h80
`define SUB_MID_TWOS       8'h00

`endif

// [logic/dac_ctrl_pkg.sv]
package dac_ctrl_pkg;
  typedef enum logic [1:0]
  {
    REF_HALF_SUPPLY = 2'h0,
    REF_BANDGAP     = 2'h1,
    REF_EXTERNAL    = 2'h2,
    REF_UNDEFINED   = 2'h3
  } ref_select_e;

  typedef enum logic [2:0]
  {
    WORD_GLOBAL  = 3'h1,
    WORD_CHANNEL = 3'h2,
    WORD_DATA    = 3'h4
  } word_kind_e;

  typedef logic [15:0] serial_word_t;
endpackage

// [logic/word_if.sv]
`timescale 1ns/100ps
// carries one complete serial word from the shifter to the register file
interface word_if;
  logic                       valid;
  dac_ctrl_pkg::serial_word_t data;

  modport source
  (
    output valid,
    output data
  );
  modport sink
  (
    input valid,
    input data
  );
endinterface

// [logic/pin_sync.sv]
`timescale 1ns/100ps
// three-stage synchroniser; a change counts once stages two and three agree
module pin_sync
(
  input  wire logic sys_clk_in,
  input  wire logic rstn_in,
  input  wire logic pin_in,
  input  wire logic reset_level_in,
  output logic      level_out,
  output logic      rise_out,
  output logic      fall_out
);
  logic [2:0] stage;

  // stage 0 feeds only stage 1
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      stage <= 3'h0;
    else
      stage <= {stage[1:0], pin_in};
  end

  // filtered level only moves when stages agree
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      level_out <= 1'b0;
    else if (stage[1] == stage[2])
      level_out <= stage[2];
  end

  assign rise_out = (stage[1] == stage[2]) && stage[2] && !level_out;
  assign fall_out = (stage[1] == stage[2]) && !stage[2] && level_out;

  // reset level input reserved for pins idling high
  logic unused_reset_level;
  assign unused_reset_level = reset_level_in;
endmodule

// [logic/serial_shifter.sv]
`timescale 1ns/100ps
`include "dac_ctrl_consts.svh"
// shifts 16 bits msb first on falling serial clock while frame sync is low
module serial_shifter
(
  input  wire logic sys_clk_in,
  input  wire logic rstn_in,
  input  wire logic frame_active_in,
  input  wire logic clock_fall_in,
  input  wire logic data_bit_in,
  word_if.source    word
);
  logic [15:0] shift;
  logic [4:0]  count;

  // collect bits; extra bits beyond sixteen in one frame are dropped
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      shift <= 16'h0000;
      count <= 5'h00;
    end
    else if (!frame_active_in)
      count <= 5'h00;
    else if (clock_fall_in && count != 5'(`WORD_BITS))
    begin
      shift <= {shift[14:0], data_bit_in}; // see R17
      count <= count + 5'h01;
    end
  end

  // one-cycle word strobe on the sixteenth bit
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      word.valid <= 1'b0;
      word.data  <= 16'h0000;
    end
    else
    begin
      word.valid <= frame_active_in && clock_fall_in
                    && count == 5'(`WORD_BITS - 1);
      word.data  <= {shift[14:0], data_bit_in};
    end
  end
endmodule

// [logic/dac_ctrl.sv]
`timescale 1ns/100ps
`include "dac_ctrl_consts.svh"
//
// Function
// R1 - mode bits 00 write global control, 01 write addressed channel control
// R2 - power_down_n low powers down reference and all channels
// R3 - registers keep their contents throughout power-down
// R4 - coding_select: 0 twos complement, 1 offset binary, for all channels
// R5 - global_standby 1 puts all channels in standby, reference kept
// R6 - global_soft_clear 1 clears every main data and output register
// R7 - cleared main code is midscale (twos) or lowest code (binary)
// R8 - global clear leaves offset converter data untouched
// R9 - three-bit address picks channel; quad part ignores top bit
// R10 - channel_standby_n 0 puts only the addressed channel in standby
// R11 - channel clear resets only that channel's main converter
// R12 - channel clear acts on the next load strobe after the write
// R13 - ref select: 00 half supply, 01 bandgap, 10 external, 11 undefined
// R14 - data word bit 15 picks offset (1) or main (0) data register
// R15 - offset data is eight bits; word bits 1 and 0 ignored
// R16 - offset code uses the same coding as the main converter
// R17 - sample one bit per falling serial clock while frame low, msb first
// R18 - mode bits at 14 and 13; upper mode 1 means data write
// R19 - load strobe low copies all data registers into output registers
// R20 - clear_n low resets main and offset data and output registers
// R21 - address bits 12..10, main data 9..0, offset data 9..2
module dac_ctrl
#(
  parameter int CHANNELS = 8
)
(
  input  wire logic                      sys_clk_in,
  input  wire logic                      rstn_in,
  input  wire logic                      frame_sync_n_in,
  input  wire logic                      serial_clock_in,
  input  wire logic                      serial_data_in,
  input  wire logic                      output_load_strobe_n_in,
  input  wire logic                      clear_n_in,
  output logic                           power_down_n_out,
  output logic                           coding_select_out,
  output logic [CHANNELS-1:0]            channel_active_out,
  output logic [CHANNELS-1:0]            channel_hiz_out,
  output logic [CHANNELS*2-1:0]          ref_select_out,
  output logic [CHANNELS*10-1:0]         main_output_out,
  output logic [CHANNELS*8-1:0]          offset_output_out
);
  localparam int AW = (CHANNELS > 4) ? 3 : 2;

  // synchronised pin levels and edges
  logic frame_level;
  logic clk_level;
  logic clk_fall;
  logic data_level;
  logic load_fall;
  logic load_level;
  logic hw_clear_level;

  pin_sync sync_frame
  (
    .sys_clk_in     (sys_clk_in),
    .rstn_in        (rstn_in),
    .pin_in         (frame_sync_n_in),
    .reset_level_in (1'b1),
    .level_out      (frame_level),
    .rise_out       (),
    .fall_out       ()
  );
  pin_sync sync_clock
  (
    .sys_clk_in     (sys_clk_in),
    .rstn_in        (rstn_in),
    .pin_in         (serial_clock_in),
    .reset_level_in (1'b0),
    .level_out      (clk_level),
    .rise_out       (),
    .fall_out       (clk_fall)
  );
  pin_sync sync_data
  (
    .sys_clk_in     (sys_clk_in),
    .rstn_in        (rstn_in),
    .pin_in         (serial_data_in),
    .reset_level_in (1'b0),
    .level_out      (data_level),
    .rise_out       (),
    .fall_out       ()
  );
  pin_sync sync_load
  (
    .sys_clk_in     (sys_clk_in),
    .rstn_in        (rstn_in),
    .pin_in         (output_load_strobe_n_in),
    .reset_level_in (1'b1),
    .level_out      (load_level),
    .rise_out       (),
    .fall_out       (load_fall)
  );
  pin_sync sync_clear
  (
    .sys_clk_in     (sys_clk_in),
    .rstn_in        (rstn_in),
    .pin_in         (clear_n_in),
    .reset_level_in (1'b1),
    .level_out      (hw_clear_level),
    .rise_out       (),
    .fall_out       ()
  );

  // the synchroniser resets its level low, so a frame would look open
  // right after reset; a shifter count of zero with no clock fall is
  // harmless, but track release so idle-high pins are seen properly
  logic pins_settled;
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      pins_settled <= 1'b0;
    else if (frame_level && load_level && hw_clear_level)
      pins_settled <= 1'b1;
  end

  word_if word ();

  serial_shifter shifter
  (
    .sys_clk_in      (sys_clk_in),
    .rstn_in         (rstn_in),
    .frame_active_in (pins_settled && !frame_level),
    .clock_fall_in   (clk_fall),
    .data_bit_in     (data_level),
    .word            (word.source)
  );

  // classify a finished word by its mode bits
  function automatic dac_ctrl_pkg::word_kind_e kind_of
  (
    input dac_ctrl_pkg::serial_word_t w
  );
    if (w[`BIT_MODE_HI])
      kind_of = dac_ctrl_pkg::WORD_DATA;       // see R18
    else if (w[`BIT_MODE_LO])
      kind_of = dac_ctrl_pkg::WORD_CHANNEL;    // see R1
    else
      kind_of = dac_ctrl_pkg::WORD_GLOBAL;     // see R1
  endfunction

  // channel index from the address field; quad part drops the top bit
  function automatic logic [AW-1:0] chan_of
  (
    input dac_ctrl_pkg::serial_word_t w
  );
    chan_of = w[`ADDR_LSB +: AW]; // see R9 see R21
  endfunction

  // clear code of the main converter for the present coding
  function automatic logic [9:0] main_clear_code(input logic binary);
    main_clear_code = binary ? `MAIN_LOW : `MAIN_MID; // see R7
  endfunction

  dac_ctrl_pkg::word_kind_e kind;
  logic [AW-1:0]            chan;
  logic                     load_now;
  logic                     hw_clear;
  assign kind     = kind_of(word.data);
  assign chan     = chan_of(word.data);
  assign load_now = pins_settled && load_fall;
  assign hw_clear = pins_settled && !hw_clear_level;

  // global control register
  logic power_down_n;
  logic coding_select;
  logic global_standby;
  logic global_soft_clear;
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      power_down_n      <= `RST_POWER_DOWN_N;
      coding_select     <= `RST_CODING;
      global_standby    <= `RST_GLOBAL_CHANNEL_STANDBY_N;
      global_soft_clear <= 1'b0;
    end
    else if (word.valid && kind == dac_ctrl_pkg::WORD_GLOBAL)
    begin
      power_down_n      <= word.data[`BIT_POWER_DOWN_N]; // see R2
      coding_select     <= word.data[`BIT_CODING];       // see R4
      global_standby    <= word.data[`BIT_GLOBAL_CHANNEL_STANDBY_N];  // see R5
      global_soft_clear <= word.data[`BIT_GLOBAL_CLR];   // see R6
    end
  end

  // channel control registers
  logic [CHANNELS-1:0] channel_standby_n;
  logic [CHANNELS-1:0] chan_clear;
  logic [1:0]          ref_sel [CHANNELS];
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      channel_standby_n <= {CHANNELS{`RST_CHAN_CHANNEL_STANDBY_N_N}};
      chan_clear        <= {CHANNELS{`RST_CHAN_CLR}};
      for (int i = 0; i < CHANNELS; i++)
        ref_sel[i] <= `RST_REF_SEL;
    end
    else if (word.valid && kind == dac_ctrl_pkg::WORD_CHANNEL)
    begin
      channel_standby_n[chan] <= word.data[`BIT_CHAN_CHANNEL_STANDBY_N_N]; // see R10
      chan_clear[chan]        <= word.data[`BIT_CHAN_CLR];    // see R11
      ref_sel[chan] <= {word.data[`BIT_REF_HI],
                        word.data[`BIT_REF_LO]};              // see R13
    end
  end

  // main data; a set soft clear holds it at the clear code and wins
  // over a coincident write; power-down gates nothing (see R3)
  logic [9:0] main_data [CHANNELS];
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      for (int i = 0; i < CHANNELS; i++)
        main_data[i] <= `MAIN_MID;
    end
    else if (hw_clear)
    begin
      for (int i = 0; i < CHANNELS; i++)
        main_data[i] <= main_clear_code(coding_select); // see R20
    end
    else if (global_soft_clear)
    begin
      for (int i = 0; i < CHANNELS; i++)
        main_data[i] <= main_clear_code(coding_select); // see R6
    end
    else if (word.valid && kind == dac_ctrl_pkg::WORD_DATA
             && !word.data[`BIT_TARGET_SUB])                 // see R14
      main_data[chan] <= word.data[`MAIN_MSB:`MAIN_LSB];
  end

  // offset data; only the hard clear touches it, never a soft one
  logic [7:0] sub_data [CHANNELS];
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      for (int i = 0; i < CHANNELS; i++)
        sub_data[i] <= `SUB_MID_TWOS;
    end
    else if (hw_clear)
    begin
      for (int i = 0; i < CHANNELS; i++)
        sub_data[i] <= coding_select ? `SUB_MID_BIN
                                     : `SUB_MID_TWOS; // see R16
    end
    else if (word.valid && kind == dac_ctrl_pkg::WORD_DATA
             && word.data[`BIT_TARGET_SUB])                  // see R14 see R8
      sub_data[chan] <= word.data[`SUB_MSB:`SUB_LSB];        // see R15
  end

  // main output registers; soft clears beat a coincident load strobe
  logic [9:0] main_out [CHANNELS];
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      for (int i = 0; i < CHANNELS; i++)
        main_out[i] <= `MAIN_MID;
    end
    else if (hw_clear)
    begin
      for (int i = 0; i < CHANNELS; i++)
        main_out[i] <= main_clear_code(coding_select); // see R20
    end
    else
    begin
      for (int i = 0; i < CHANNELS; i++)
      begin
        if (global_soft_clear)
          main_out[i] <= main_clear_code(coding_select); // see R6
        else if (load_now && chan_clear[i])
          main_out[i] <= main_clear_code(coding_select); // see R12 see R11
        else if (load_now)
          main_out[i] <= main_data[i];                   // see R19
      end
    end
  end

  // offset output registers follow only the load strobe and hard clear
  logic [7:0] sub_out [CHANNELS];
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      for (int i = 0; i < CHANNELS; i++)
        sub_out[i] <= `SUB_MID_TWOS;
    end
    else if (hw_clear)
    begin
      for (int i = 0; i < CHANNELS; i++)
        sub_out[i] <= coding_select ? `SUB_MID_BIN : `SUB_MID_TWOS;
    end
    else if (load_now)
    begin
      for (int i = 0; i < CHANNELS; i++)
        sub_out[i] <= sub_data[i];                       // see R19
    end
  end

  // global pins toward the analog side, all from flip-flops
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      power_down_n_out  <= `RST_POWER_DOWN_N;
      coding_select_out <= `RST_CODING;
    end
    else
    begin
      power_down_n_out  <= power_down_n;                  // see R2
      coding_select_out <= coding_select;                 // see R4
    end
  end

  // per-channel run state; standby ties the output low through high
  // impedance, so active and high impedance never overlap (see R5, R10)
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      channel_active_out <= '0;
      channel_hiz_out    <= '1;
      ref_select_out     <= '0;
    end
    else
    begin
      for (int i = 0; i < CHANNELS; i++)
      begin
        channel_active_out[i] <= power_down_n && !global_standby
                                 && channel_standby_n[i];
        channel_hiz_out[i]    <= !power_down_n || global_standby
                                 || !channel_standby_n[i];
        ref_select_out[2*i +: 2] <= ref_sel[i];          // see R13
      end
    end
  end

  // converter codes; they move only through the output registers
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      main_output_out   <= '0;
      offset_output_out <= '0;
    end
    else
    begin
      for (int i = 0; i < CHANNELS; i++)
      begin
        main_output_out[10*i +: 10] <= main_out[i];
        offset_output_out[8*i +: 8] <= sub_out[i];
      end
    end
  end

  // serial clock level is only used for edge finding
  logic unused_clk_level;
  assign unused_clk_level = clk_level;
endmodule

// [verif/dac_ctrl_sva.sv]
`timescale 1ns/100ps
`include "dac_ctrl_consts.svh"
// pin-level checks for the converter control block
module dac_ctrl_sva
#(
  parameter int CHANNELS = 8
)
(
  input wire logic                   sys_clk_in,
  input wire logic                   rstn_in,
  input wire logic                   frame_sync_n_in,
  input wire logic                   output_load_strobe_n_in,
  input wire logic                   clear_n_in,
  input wire logic                   power_down_n_out,
  input wire logic                   coding_select_out,
  input wire logic [CHANNELS-1:0]    channel_active_out,
  input wire logic [CHANNELS-1:0]    channel_hiz_out,
  input wire logic [CHANNELS*2-1:0]  ref_select_out,
  input wire logic [CHANNELS*10-1:0] main_output_out,
  input wire logic [CHANNELS*8-1:0]  offset_output_out
);
  logic [3:0] idle_frame;
  logic [3:0] idle_pins;
  logic       pins_busy;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rstn_in);

  assign pins_busy = !output_load_strobe_n_in || !clear_n_in;

  // cycles since pin activity; zero at reset so start-up settling passes
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      idle_frame <= 4'h0;
      idle_pins  <= 4'h0;
    end
    else
    begin
      idle_frame <= !frame_sync_n_in ? 4'h0
                    : idle_frame + 4'(idle_frame != 4'hF);
      idle_pins  <= pins_busy ? 4'h0 : idle_pins + 4'(idle_pins != 4'hF);
    end
  end

  pd_stops_all_a : assert property
    (!power_down_n_out |-> channel_active_out == '0 && &channel_hiz_out)
    else $error("channel running while powered down");
  active_not_hiz_a : assert property
    ((channel_active_out & channel_hiz_out) == '0)
    else $error("channel both running and high impedance");
  ctrl_by_frame_a : assert property
    (!$stable({power_down_n_out, coding_select_out, channel_active_out,
      ref_select_out}) |-> idle_frame < 4'hC)
    else $error("control output moved without a frame");
  main_cause_a : assert property
    ($changed(main_output_out) |-> idle_frame < 4'hC || idle_pins < 4'hC)
    else $error("main output moved without cause");
  offset_cause_a : assert property
    ($changed(offset_output_out) |-> idle_pins < 4'hC)
    else $error("offset output moved without load or clear");
  hw_clear_main_a : assert property
    (!clear_n_in [*8] |-> main_output_out ==
      {CHANNELS{coding_select_out ? `MAIN_LOW : `MAIN_MID}})
    else $error("main output not at clear code");
  hw_clear_off_a : assert property
    (!clear_n_in [*8] |-> offset_output_out ==
      {CHANNELS{coding_select_out ? `SUB_MID_BIN : `SUB_MID_TWOS}})
    else $error("offset output not at clear code");
  load_once_a : assert property
    ($fell(output_load_strobe_n_in) && clear_n_in && idle_frame == 4'hF
      |-> ##8 $stable(main_output_out) [*4])
    else $error("main output moved long after load");

  load_seen_c : cover property ($fell(output_load_strobe_n_in));
  clear_seen_c : cover property (!clear_n_in [*8]);
  ref_moved_c : cover property ($changed(ref_select_out));
endmodule

bind dac_ctrl dac_ctrl_sva #(.CHANNELS(CHANNELS)) i_sva
(
  .sys_clk_in, .rstn_in, .frame_sync_n_in, .output_load_strobe_n_in,
  .clear_n_in, .power_down_n_out, .coding_select_out, .channel_active_out,
  .channel_hiz_out, .ref_select_out, .main_output_out, .offset_output_out
);

// [verif/host_model.sv]
`timescale 1ns/100ps
// serial host: sixteen-bit frames, load strobe and clear pin
module host_model
(
  input  wire logic sys_clk_in,
  output logic      frame_sync_n_out,
  output logic      serial_clock_out,
  output logic      serial_data_out,
  output logic      output_load_strobe_n_out,
  output logic      clear_n_out
);
  // idle pins high except data, which idles low; clock parked between frames
  initial
  begin
    frame_sync_n_out = 1'b1;
    serial_clock_out = 1'b1;
    serial_data_out = 1'b0;
    output_load_strobe_n_out = 1'b1;
    clear_n_out = 1'b1;
  end

  // all changes land 1 ns after a rising edge
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask

  // 400 ns serial clock; bit set while high, taken on the fall
  task automatic send(input dac_ctrl_pkg::serial_word_t w);
    wait_cyc(1);
    frame_sync_n_out = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      serial_data_out = w[i];
      wait_cyc(4);
      serial_clock_out = 1'b0;
      wait_cyc(4);
      serial_clock_out = 1'b1;
    end
    frame_sync_n_out = 1'b1;
    // released line must not keep showing the last bit
    serial_data_out = ~w[0];
    wait_cyc(16);
  endtask

  // strobe held four cycles so the synchroniser sees it
  task automatic load();
    wait_cyc(1);
    output_load_strobe_n_out = 1'b0;
    wait_cyc(4);
    output_load_strobe_n_out = 1'b1;
    wait_cyc(8);
  endtask

  task automatic set_clear(input logic level);
    wait_cyc(1);
    clear_n_out = level;
    wait_cyc(12);
  endtask
endmodule

// [verif/testbench.sv]
`timescale 1ns/100ps
// self-checking bench for the converter control block
module testbench;
  typedef struct packed
  {
    logic [15:0] word;
    logic [2:0]  chan;
    logic        sub;
    logic [9:0]  want;
  } row_s;

  // data writes: word, channel, offset target, expected code
  localparam row_s ROWS [7] = '{
    '{16'h2200, 3'h0, 1'b0, 10'h200},
    '{16'hA200, 3'h0, 1'b1, 10'h080},
    '{16'hA3FF, 3'h0, 1'b1, 10'h0FF},
    '{16'h7D55, 3'h7, 1'b0, 10'h155},
    '{16'h2401, 3'h1, 1'b0, 10'h001},
    '{16'hA403, 3'h1, 1'b1, 10'h000},
    '{16'hB6FC, 3'h5, 1'b1, 10'h0BF}
  };

  logic        sys_clk_in;
  logic        rstn_in;
  logic        frame_sync_n_in;
  logic        serial_clock_in;
  logic        serial_data_in;
  logic        output_load_strobe_n_in;
  logic        clear_n_in;
  logic        power_down_n_out;
  logic        coding_select_out;
  logic [7:0]  channel_active_out;
  logic [7:0]  channel_hiz_out;
  logic [15:0] ref_select_out;
  logic [79:0] main_output_out;
  logic [63:0] offset_output_out;
  logic [15:0] got;
  row_s        row;
  int          n_fail;
  int          samples_checked;

  host_model i_host
  (
    .sys_clk_in               (sys_clk_in),
    .frame_sync_n_out         (frame_sync_n_in),
    .serial_clock_out         (serial_clock_in),
    .serial_data_out          (serial_data_in),
    .output_load_strobe_n_out (output_load_strobe_n_in),
    .clear_n_out              (clear_n_in)
  );

  dac_ctrl #(.CHANNELS(8)) i_dut
  (
    .sys_clk_in              (sys_clk_in),
    .rstn_in                 (rstn_in),
    .frame_sync_n_in         (frame_sync_n_in),
    .serial_clock_in         (serial_clock_in),
    .serial_data_in          (serial_data_in),
    .output_load_strobe_n_in (output_load_strobe_n_in),
    .clear_n_in              (clear_n_in),
    .power_down_n_out        (power_down_n_out),
    .coding_select_out       (coding_select_out),
    .channel_active_out      (channel_active_out),
    .channel_hiz_out         (channel_hiz_out),
    .ref_select_out          (ref_select_out),
    .main_output_out         (main_output_out),
    .offset_output_out       (offset_output_out)
  );

  initial sys_clk_in = 1'b0;
  always #25 sys_clk_in = ~sys_clk_in;

  // one channel's fields, widened for comparison
  function automatic logic [15:0] main_of(input int ch);
    return {6'h0, main_output_out[ch*10+:10]};
  endfunction
  function automatic logic [15:0] off_of(input int ch);
    return {8'h0, offset_output_out[ch*8+:8]};
  endfunction
  function automatic logic [15:0] ref_of(input int ch);
    return {14'h0, ref_select_out[ch*2+:2]};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // reset, table of data writes, then hand-written cases
  initial
  begin
    n_fail = 0;
    samples_checked = 0;
    rstn_in = 1'b0;
    repeat (3) @(posedge sys_clk_in);
    #1;
    check(16'(channel_hiz_out), 16'h00FF);
    check({15'h0, power_down_n_out}, 16'h0001);
    rstn_in = 1'b1;
    i_host.wait_cyc(8);
    i_host.send(16'h0060);
    check({15'h0, coding_select_out}, 16'h0001);
    check(16'(channel_active_out), 16'h00FF);
    for (int i = 0; i < 7; i++)
    begin
      row = ROWS[i];
      i_host.send(row.word);
      i_host.load();
      got = row.sub ? off_of(row.chan) : main_of(row.chan);
      check(got, 16'(row.want));
    end
    // every reference code on a different channel
    for (int r = 0; r < 4; r++)
    begin
      i_host.send({3'b010, 3'(r + 2), 2'(r), 8'h10});
      check(ref_of(r + 2), 16'(r));
    end
    i_host.send(16'h4C00);
    check(16'(channel_active_out), 16'h00F7);
    check(16'(channel_hiz_out), 16'h0008);
    i_host.send(16'h4C10);
    i_host.send(16'h0040);
    check(16'(channel_active_out), 16'h0000);
    i_host.send(16'h0060);
    i_host.load();
    check(main_of(7), 16'h0155);
    check(ref_of(5), 16'h0003);
    // channel clear waits for the strobe
    i_host.send(16'hA4A8);
    i_host.send(16'h2523);
    i_host.load();
    i_host.send(16'h4418);
    check(main_of(1), 16'h0123);
    i_host.load();
    check(main_of(1), 16'h0000);
    check(off_of(1), 16'h002A);
    check(main_of(7), 16'h0155);
    i_host.send(16'h4410);
    // software clear under both codings
    i_host.send(16'h0068);
    check(main_of(0), 16'h0000);
    check(off_of(0), 16'h00FF);
    i_host.send(16'h0028);
    check(main_of(0), 16'h0200);
    i_host.send(16'h0060);
    i_host.set_clear(1'b0);
    check(main_of(7), 16'h0000);
    check(off_of(5), 16'h0080);
    i_host.set_clear(1'b1);
    // hard clear again under twos complement coding
    i_host.send(16'h0020);
    i_host.set_clear(1'b0);
    check(main_of(7), 16'h0200);
    check(off_of(5), 16'h0000);
    i_host.set_clear(1'b1);
    summarize();
  end

  // the sequence needs about 0.2 ms; stop a hang well after that
  initial
  begin
    #2000000;
    n_fail++;
    summarize();
  end
endmodule
